// >>> src/pbc_regs.sv
// Top of the power budget capability register block with its AXI4-Lite slave
`timescale 1ns/1ps

// Overview of operation
// - Header bits 15:0 hold the capability id, reset zero; 0x4 means power budget.
// - Header bits 19:16 hold the capability version, reset zero; 0x1 is revision 2.0.
// - Header bits 31:20 hold the next pointer; zero ends the capability chain.
// - Select register bits 7:0 are read-write, reset zero; bits 31:8 read zero.
// - A select value above seven makes the data register read all zeros.
// - Data register is read-only and returns the selected value slot for 0..7.
// - Eight sticky 32-bit value slots accept writes only while unlocked.
module pbc_regs #(
  parameter logic [11:0] NEXT_PTR_RST_VAL = pbc_pkg::NEXT_PTR_RST
) (
  // Clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          nrst_in,
  // AXI4-Lite write address
  input  wire logic                          s_axi_awvalid_in,
  output logic                               s_axi_awready_out,
  input  wire pbc_pkg::pbc_addr_t            s_axi_awaddr_in,
  // AXI4-Lite write data
  input  wire logic                          s_axi_wvalid_in,
  output logic                               s_axi_wready_out,
  input  wire pbc_pkg::pbc_word_t            s_axi_wdata_in,
  input  wire logic [pbc_pkg::STRB_W-1:0]    s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic                               s_axi_bvalid_out,
  input  wire logic                          s_axi_bready_in,
  output logic [1:0]                         s_axi_bresp_out,
  // AXI4-Lite read address
  input  wire logic                          s_axi_arvalid_in,
  output logic                               s_axi_arready_out,
  input  wire pbc_pkg::pbc_addr_t            s_axi_araddr_in,
  // AXI4-Lite read data
  output logic                               s_axi_rvalid_out,
  input  wire logic                          s_axi_rready_in,
  output pbc_pkg::pbc_word_t                 s_axi_rdata_out,
  output logic [1:0]                         s_axi_rresp_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                       aw_held;
    pbc_pkg::pbc_addr_t         aw_addr;
    logic                       w_held;
    pbc_pkg::pbc_word_t         w_data;
    logic [pbc_pkg::STRB_W-1:0] w_strb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    pbc_pkg::pbc_word_t         rdata;
    logic [1:0]                 rresp;
    logic                       unlock;
  } pbc_top_state_s;

  pbc_top_state_s                                   state_reg;
  pbc_top_state_s                                   state_next;
  pbc_pkg::pbc_wr_s                                 wr;
  pbc_pkg::pbc_word_t                               header;
  logic [pbc_pkg::SEL_W-1:0]                        sel;
  pbc_pkg::pbc_word_t [pbc_pkg::NUM_SLOTS-1:0]      slots;
  pbc_pkg::pbc_word_t                               readout;
  logic                                             aw_hs;
  logic                                             w_hs;
  logic                                             ar_hs;
  pbc_pkg::pbc_addr_t                               ar_word;
  pbc_pkg::pbc_addr_t                               wr_word;
  pbc_pkg::pbc_word_t                               rd_value;
  logic                                             rd_mapped;
  logic                                             wr_mapped;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  // One write in flight: channels close while held or while a response waits
  assign s_axi_awready_out = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready_out  = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_arready_out = !state_reg.rvalid;
  assign aw_hs             = s_axi_awvalid_in && s_axi_awready_out;
  assign w_hs              = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_hs             = s_axi_arvalid_in && s_axi_arready_out;

  // Word-aligned addresses; the two low bits never select anything
  assign ar_word = {s_axi_araddr_in[pbc_pkg::ADDR_W-1:2], 2'b00};
  assign wr_word = {state_reg.aw_addr[pbc_pkg::ADDR_W-1:2], 2'b00};

  // Write strobe to the register banks, raised in the same cycle that both halves are held
  always_comb begin
    wr.en   = state_reg.aw_held && state_reg.w_held;
    wr.addr = wr_word;
    wr.data = state_reg.w_data;
    wr.strb = state_reg.w_strb;
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Read value, taken from live contents at the moment of the read
  always_comb begin
    rd_value  = '0;
    rd_mapped = 1'b1;
    if (ar_word == pbc_pkg::PBC_CAP_HEADER_OFS) begin
      rd_value = header;
    end else if (ar_word == pbc_pkg::PBC_DATA_SELECT_OFS) begin
      rd_value = {{(pbc_pkg::DATA_W - pbc_pkg::SEL_W){1'b0}}, sel};
    end else if (ar_word == pbc_pkg::PBC_DATA_READOUT_OFS) begin
      rd_value = readout;
    end else if (ar_word == pbc_pkg::PBC_SWITCH_CTRL_OFS) begin
      rd_value[pbc_pkg::UNLOCK_BIT] = state_reg.unlock;
    end else if (ar_word >= pbc_pkg::PBC_SLOT_BASE_OFS &&
                 ar_word <= pbc_pkg::PBC_SLOT_LAST_OFS) begin
      rd_value = slots[ar_word[4:2]];
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // Writes to read-only words are accepted and dropped, not refused
  always_comb begin
    wr_mapped = (wr_word == pbc_pkg::PBC_CAP_HEADER_OFS)   ||
                (wr_word == pbc_pkg::PBC_DATA_SELECT_OFS)  ||
                (wr_word == pbc_pkg::PBC_DATA_READOUT_OFS) ||
                (wr_word == pbc_pkg::PBC_SWITCH_CTRL_OFS)  ||
                (wr_word >= pbc_pkg::PBC_SLOT_BASE_OFS &&
                 wr_word <= pbc_pkg::PBC_SLOT_LAST_OFS);
  end

  // ----------------------------------------------------------------
  // Bus slave next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // Capture each write half independently, either order
    if (aw_hs) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr_in;
    end
    if (w_hs) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata_in;
      state_next.w_strb = s_axi_wstrb_in;
    end
    // Commit and answer once both halves are in
    if (wr.en) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = wr_mapped ? pbc_pkg::RESP_OKAY : pbc_pkg::RESP_DECERR;
      if (wr_word == pbc_pkg::PBC_SWITCH_CTRL_OFS && wr.strb[0]) begin
        state_next.unlock = wr.data[pbc_pkg::UNLOCK_BIT];
      end
    end else if (state_reg.bvalid && s_axi_bready_in) begin
      state_next.bvalid = 1'b0;
    end
    // Read answer registered one cycle after the address is taken
    if (ar_hs) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_value;
      state_next.rresp  = rd_mapped ? pbc_pkg::RESP_OKAY : pbc_pkg::RESP_DECERR;
    end else if (state_reg.rvalid && s_axi_rready_in) begin
      state_next.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg        <= '0;
      state_reg.unlock <= pbc_pkg::UNLOCK_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_bvalid_out = state_reg.bvalid;
  assign s_axi_bresp_out  = state_reg.bresp;
  assign s_axi_rvalid_out = state_reg.rvalid;
  assign s_axi_rdata_out  = state_reg.rdata;
  assign s_axi_rresp_out  = state_reg.rresp;

  // ----------------------------------------------------------------
  // Register banks
  // ----------------------------------------------------------------
  pbc_cap_header #(
    .NEXT_PTR_RST_VAL (NEXT_PTR_RST_VAL)
  ) u_header (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .wr_in      (wr),
    .unlock_in  (state_reg.unlock),
    .header_out (header),
    .select_out (sel)
  );

  pbc_value_bank #(
    .NUM_SLOTS (pbc_pkg::NUM_SLOTS)
  ) u_bank (
    .ref_clk_in  (ref_clk_in),
    .nrst_in     (nrst_in),
    .wr_in       (wr),
    .unlock_in   (state_reg.unlock),
    .select_in   (sel),
    .slots_out   (slots),
    .readout_out (readout)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic rd_hdr;
  logic rd_data;
  logic rd_sel;
  assign rd_hdr  = ar_hs && ar_word == pbc_pkg::PBC_CAP_HEADER_OFS;
  assign rd_data = ar_hs && ar_word == pbc_pkg::PBC_DATA_READOUT_OFS;
  assign rd_sel  = ar_hs && ar_word == pbc_pkg::PBC_DATA_SELECT_OFS;

  chk_capability_identifier_readback: assert property (
    rd_hdr |=> s_axi_rvalid_out && s_axi_rdata_out[15:0] == $past(header[15:0]))
    else $error("capability id readback mismatch");

  chk_version_readback: assert property (
    rd_hdr |=> s_axi_rdata_out[19:16] == $past(header[19:16]))
    else $error("capability version readback mismatch");

  chk_next_ptr_readback: assert property (
    rd_hdr |=> s_axi_rdata_out[31:20] == $past(header[31:20]))
    else $error("next pointer readback mismatch");

  chk_header_locked: assert property (
    (wr.en && !state_reg.unlock && wr.addr == pbc_pkg::PBC_CAP_HEADER_OFS)
      |=> $stable(header))
    else $error("header changed while locked");

  chk_select_write: assert property (
    (wr.en && wr.strb[0] && wr.addr == pbc_pkg::PBC_DATA_SELECT_OFS)
      |=> sel == $past(wr.data[7:0]) ##1 1'b1)
    else $error("select field did not take the write");

  chk_select_upper_zero: assert property (
    rd_sel |=> s_axi_rdata_out[31:8] == 24'h000000)
    else $error("select upper bits not zero");

  chk_data_oob_zero: assert property (
    (rd_data && sel > 8'h07) |=> s_axi_rdata_out == 32'h0000_0000)
    else $error("out of range select did not read zero");

  chk_data_in_range: assert property (
    (rd_data && sel <= 8'h07) |=> s_axi_rdata_out == $past(slots[sel[2:0]]))
    else $error("data readout differs from selected slot");

  chk_data_readonly: assert property (
    (wr.en && wr.addr == pbc_pkg::PBC_DATA_READOUT_OFS) |=> $stable(slots) && $stable(sel))
    else $error("write to data readout changed state");

  chk_new_select_seen: assert property (
    (wr.en && wr.strb[0] && wr.addr == pbc_pkg::PBC_DATA_SELECT_OFS) ##[1:8] rd_data
      |=> s_axi_rdata_out == ($past(sel) > 8'h07 ? 32'h0000_0000 : $past(slots[sel[2:0]])))
    else $error("new selection not visible on next read");

  chk_slot_locked: assert property (
    (wr.en && !state_reg.unlock) |=> $stable(slots))
    else $error("value slot changed while locked");

  chk_write_answer: assert property (
    wr.en |=> s_axi_bvalid_out [*1] ##0 !s_axi_awready_out)
    else $error("write response not raised after commit");

  chk_read_hold: assert property (
    (s_axi_rvalid_out && !s_axi_rready_in) |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped before taken");

  // Byte lanes, decode and answer timing; a strobe without byte 0 must not change select
  chk_select_lane_gate: assert property (
    (wr.en && !wr.strb[0] && wr.addr == pbc_pkg::PBC_DATA_SELECT_OFS) |=> $stable(sel))
    else $error("select changed without byte 0 strobe");

  chk_slot_full_write: assert property (
    (wr.en && state_reg.unlock && wr.strb == 4'hF && wr.addr == pbc_pkg::PBC_SLOT_BASE_OFS)
      |=> slots[0] == $past(wr.data))
    else $error("unlocked full word write not stored");

  chk_readout_oob_comb: assert property (
    sel > 8'h07 |-> readout == 32'h0000_0000)
    else $error("readout not zero for out of range select");

  chk_read_answer: assert property (
    ar_hs |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer not raised after address taken");

  chk_unmapped_read: assert property (
    (ar_hs && !rd_mapped) |=> s_axi_rresp_out == pbc_pkg::RESP_DECERR && s_axi_rdata_out == '0)
    else $error("unmapped read not refused");

  cov_unlocked_slot_write: cover property (
    wr.en && state_reg.unlock && wr.addr == pbc_pkg::PBC_SLOT_BASE_OFS);
  cov_select_then_read: cover property (
    (wr.en && wr.addr == pbc_pkg::PBC_DATA_SELECT_OFS) ##[1:4] rd_data);
  cov_oob_read: cover property (rd_data && sel > 8'h07);
  cov_unmapped_read: cover property (ar_hs && !rd_mapped);

endmodule : pbc_regs

// >>> inc/pbc_pkg.sv
// Shared constants, types and helpers of the power budget capability registers
package pbc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int STRB_W    = 4;
  localparam int NUM_SLOTS = 8;

  typedef logic [ADDR_W-1:0] pbc_addr_t;
  typedef logic [DATA_W-1:0] pbc_word_t;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam pbc_addr_t PBC_CAP_HEADER_OFS  = 12'h280;
  localparam pbc_addr_t PBC_DATA_SELECT_OFS = 12'h284;
  localparam pbc_addr_t PBC_DATA_READOUT_OFS = 12'h288;
  localparam pbc_addr_t PBC_SLOT_BASE_OFS   = 12'h300;
  localparam pbc_addr_t PBC_SLOT_LAST_OFS   = 12'h31C;
  localparam pbc_addr_t PBC_SLOT_STRIDE     = 12'h004;
  localparam pbc_addr_t PBC_SWITCH_CTRL_OFS = 12'h3F0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CAP_ID_LSB   = 0;
  localparam int CAP_ID_W     = 16;
  localparam int CAP_VER_LSB  = 16;
  localparam int CAP_VER_W    = 4;
  localparam int NEXT_PTR_LSB = 20;
  localparam int NEXT_PTR_W   = 12;
  localparam int SEL_W        = 8;
  localparam int UNLOCK_BIT   = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CAP_ID_W-1:0]   CAP_ID_RST   = 16'h0000;
  localparam logic [CAP_VER_W-1:0]  CAP_VER_RST  = 4'h0;
  localparam logic [NEXT_PTR_W-1:0] NEXT_PTR_RST = 12'h000;
  localparam logic [SEL_W-1:0]      SEL_RST      = 8'h00;
  localparam logic [SEL_W-1:0]      SEL_LAST     = 8'h07;
  localparam pbc_word_t             SLOT_RST     = 32'h0000_0000;
  localparam logic                  UNLOCK_RST   = 1'b0;

  // ----------------------------------------------------------------
  // AXI4-Lite response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Internal register write strobe
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              en;
    pbc_addr_t         addr;
    pbc_word_t         data;
    logic [STRB_W-1:0] strb;
  } pbc_wr_s;

  // Byte-lane merge of a write into an old value
  function automatic pbc_word_t merge_bytes(input pbc_word_t old_v,
                                            input pbc_word_t new_v,
                                            input logic [STRB_W-1:0] strb);
    pbc_word_t res;
    res = old_v;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

endpackage : pbc_pkg

// >>> src/pbc_cap_header.sv
// Capability header and data select registers
`timescale 1ns/1ps

module pbc_cap_header #(
  parameter logic [11:0] NEXT_PTR_RST_VAL = pbc_pkg::NEXT_PTR_RST
) (
  // Clock and reset
  input  wire logic                           ref_clk_in,
  input  wire logic                           nrst_in,
  // Register write strobe and lock
  input  wire pbc_pkg::pbc_wr_s               wr_in,
  input  wire logic                           unlock_in,
  // Register contents
  output pbc_pkg::pbc_word_t                  header_out,
  output logic [pbc_pkg::SEL_W-1:0]           select_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [pbc_pkg::CAP_ID_W-1:0]   cap_id;
    logic [pbc_pkg::CAP_VER_W-1:0]  cap_ver;
    logic [pbc_pkg::NEXT_PTR_W-1:0] next_ptr;
    logic [pbc_pkg::SEL_W-1:0]      sel;
  } pbc_hdr_state_s;

  pbc_hdr_state_s state_reg;
  pbc_hdr_state_s state_next;
  pbc_pkg::pbc_word_t merged;

  // Next state: header only moves while unlocked, select writable whenever byte 0 is strobed
  always_comb begin
    state_next = state_reg;
    merged     = pbc_pkg::merge_bytes(header_out, wr_in.data, wr_in.strb);
    if (wr_in.en && unlock_in && wr_in.addr == pbc_pkg::PBC_CAP_HEADER_OFS) begin
      state_next.cap_id   = merged[pbc_pkg::CAP_ID_LSB +: pbc_pkg::CAP_ID_W];
      state_next.cap_ver  = merged[pbc_pkg::CAP_VER_LSB +: pbc_pkg::CAP_VER_W];
      state_next.next_ptr = merged[pbc_pkg::NEXT_PTR_LSB +: pbc_pkg::NEXT_PTR_W];
    end
    if (wr_in.en && wr_in.strb[0] && wr_in.addr == pbc_pkg::PBC_DATA_SELECT_OFS) begin
      state_next.sel = wr_in.data[pbc_pkg::SEL_W-1:0];
    end
  end

  // Registers, all zero except the chain pointer
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg.cap_id   <= pbc_pkg::CAP_ID_RST;
      state_reg.cap_ver  <= pbc_pkg::CAP_VER_RST;
      state_reg.next_ptr <= NEXT_PTR_RST_VAL;
      state_reg.sel      <= pbc_pkg::SEL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign header_out = {state_reg.next_ptr, state_reg.cap_ver, state_reg.cap_id};
  assign select_out = state_reg.sel;

endmodule : pbc_cap_header

// >>> src/pbc_value_bank.sv
// Eight power budget value slots with the selected-slot readout
`timescale 1ns/1ps

module pbc_value_bank #(
  parameter int NUM_SLOTS = pbc_pkg::NUM_SLOTS
) (
  // Clock and reset
  input  wire logic                                ref_clk_in,
  input  wire logic                                nrst_in,
  // Register write strobe and lock
  input  wire pbc_pkg::pbc_wr_s                    wr_in,
  input  wire logic                                unlock_in,
  // Slot selection
  input  wire logic [pbc_pkg::SEL_W-1:0]           select_in,
  // Contents
  output pbc_pkg::pbc_word_t [NUM_SLOTS-1:0]       slots_out,
  output pbc_pkg::pbc_word_t                       readout_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pbc_pkg::pbc_word_t [NUM_SLOTS-1:0] slot;
  } pbc_bank_state_s;

  pbc_bank_state_s        state_reg;
  pbc_bank_state_s        state_next;
  logic [NUM_SLOTS-1:0]   hit;

  // Per-slot address decode; locked writes never raise a hit
  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
    assign hit[i] = wr_in.en && unlock_in &&
                    wr_in.addr == pbc_pkg::PBC_SLOT_BASE_OFS +
                                  pbc_pkg::pbc_addr_t'(i * 4);
  end

  // Next state with byte lanes honoured
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (hit[i]) begin
        state_next.slot[i] = pbc_pkg::merge_bytes(state_reg.slot[i], wr_in.data,
                                                  wr_in.strb);
      end
    end
  end

  // Sticky contents: only the core reset clears them
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg.slot <= {NUM_SLOTS{pbc_pkg::SLOT_RST}};
    end else begin
      state_reg <= state_next;
    end
  end

  // Readout follows the live select, zero past the last slot
  always_comb begin
    if (select_in > pbc_pkg::SEL_LAST) begin
      readout_out = '0;
    end else begin
      readout_out = state_reg.slot[select_in[2:0]];
    end
  end

  assign slots_out = state_reg.slot;

endmodule : pbc_value_bank

// >>> verification/tb_top.sv
// Self-checking testbench of the power budget capability register block
`timescale 1ns/1ps

module tb_top;
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  localparam logic [11:0] PTR_RST = 12'h5A0; // Arbitrary, proves the parameter reaches reset
  localparam pbc_pkg::pbc_addr_t CTRL = pbc_pkg::PBC_SWITCH_CTRL_OFS;
  localparam pbc_pkg::pbc_addr_t HDR  = pbc_pkg::PBC_CAP_HEADER_OFS;
  localparam pbc_pkg::pbc_addr_t SEL  = pbc_pkg::PBC_DATA_SELECT_OFS;
  localparam pbc_pkg::pbc_addr_t RDO  = pbc_pkg::PBC_DATA_READOUT_OFS;
  localparam pbc_pkg::pbc_addr_t SLT  = pbc_pkg::PBC_SLOT_BASE_OFS;
  logic               ref_clk_in, nrst_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic [1:0]         bresp, rresp;
  logic [3:0]         wstrb;
  pbc_pkg::pbc_addr_t awaddr, araddr;
  pbc_pkg::pbc_word_t wdata, rdata, got;
  int                 n_fail, samples_checked;

  pbc_regs #(.NEXT_PTR_RST_VAL(PTR_RST)) uut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp));

  // Free-running 200 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  // ----------------------------------------------------------------
  // Compare, bus and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk_word

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s response expected %h seen %h", what, exp, seen);
    end
  endtask : chk_resp

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // Bounded wait: a hung handshake ends the run as a mismatch
  task automatic bus_hung(input int k);
    if (k >= 64) begin
      n_fail++;
      $display("wrong value handshake expected answer seen none");
      tally_and_finish();
    end
  endtask : bus_hung

  // Address and data offered together, each dropped once taken
  task automatic wr(input pbc_pkg::pbc_addr_t a, input pbc_pkg::pbc_word_t d, input logic [1:0] er);
    int k;
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge ref_clk_in);
      if (bvalid === 1'b1) break;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end
    bus_hung(k);
    chk_resp("write", er, bresp);
    bready <= 1'b0;
    @(posedge ref_clk_in);
  endtask : wr

  task automatic rd(input pbc_pkg::pbc_addr_t a, input pbc_pkg::pbc_word_t exp,
                    input logic [1:0] er);
    int k;
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge ref_clk_in);
      if (rvalid === 1'b1) break;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    bus_hung(k);
    got = rdata;
    chk_resp("read", er, rresp);
    chk_word("read data", exp, got);
    rready <= 1'b0;
    @(posedge ref_clk_in);
  endtask : rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    rd(HDR, {PTR_RST, 20'h0_0000}, 2'h0);
    rd(SEL, 32'h0, 2'h0);
    rd(RDO, 32'h0, 2'h0);
    rd(CTRL, 32'h0, 2'h0);
    $display("test reset_values done");
  endtask : t_reset_values

  // Writes while locked must leave header and slots untouched
  task automatic t_locked;
    wr(HDR, 32'h0010_0004, 2'h0);
    wr(SLT, 32'hA5A5_0001, 2'h0);
    rd(HDR, {PTR_RST, 20'h0_0000}, 2'h0);
    rd(SLT, 32'h0, 2'h0);
    $display("test locked_writes done");
  endtask : t_locked

  task automatic t_fill;
    wr(CTRL, 32'h0000_0001, 2'h0);
    rd(CTRL, 32'h0000_0001, 2'h0);
    wr(HDR, 32'h0010_0004, 2'h0);
    rd(HDR, 32'h0010_0004, 2'h0);
    for (int i = 0; i < 8; i++) wr(SLT + 12'(4 * i), 32'h1357_0000 + 32'(i * 273), 2'h0);
    // Back-to-back select changes, each seen by the very next read
    for (int i = 0; i < 8; i++) begin
      wr(SEL, 32'(i), 2'h0);
      rd(RDO, 32'h1357_0000 + 32'(i * 273), 2'h0);
    end
    // Only byte 1 enabled: the other lanes of slot 0 keep their value
    wstrb <= 4'h2;
    wr(SLT, 32'hFFFF_FFFF, 2'h0);
    wstrb <= 4'hF;
    rd(SLT, 32'h1357_FF00, 2'h0);
    wr(CTRL, 32'h0, 2'h0);
    wr(SLT + 12'h01C, 32'hFFFF_FFFF, 2'h0);
    rd(SLT + 12'h01C, 32'h1357_0777, 2'h0);
    $display("test unlock_fill done");
  endtask : t_fill

  task automatic t_select;
    wr(SEL, 32'h0000_0008, 2'h0);
    rd(RDO, 32'h0, 2'h0);
    wr(SEL, 32'hFFFF_FFFF, 2'h0);
    rd(SEL, 32'h0000_00FF, 2'h0);
    rd(RDO, 32'h0, 2'h0);
    wr(SEL, 32'hFFFF_FF07, 2'h0);
    wr(RDO, 32'hFFFF_FFFF, 2'h0);
    wstrb <= 4'hE;
    wr(SEL, 32'h0000_0003, 2'h0);
    wstrb <= 4'hF;
    rd(SEL, 32'h0000_0007, 2'h0);
    rd(RDO, 32'h1357_0777, 2'h0);
    $display("test select_range done");
  endtask : t_select

  task automatic t_unmapped;
    wr(12'h200, 32'hFFFF_FFFF, pbc_pkg::RESP_DECERR);
    rd(12'h200, 32'h0, pbc_pkg::RESP_DECERR);
    $display("test unmapped done");
  endtask : t_unmapped

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0; samples_checked = 0; nrst_in = 1'b0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hF;
    repeat (16) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    @(posedge ref_clk_in);
    t_reset_values();
    t_locked();
    t_fill();
    t_select();
    t_unmapped();
    // Second reset in mid-run: every register, slots too, back to its reset value
    nrst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    @(posedge ref_clk_in);
    t_reset_values();
    tally_and_finish();
  end
endmodule : tb_top
